//--- rcs_seq.sv
/*
 * Read-cycle sequencer with AXI4-Lite registers and its result FIFO.
 * Assumes a synchronous serial receiver byte strobe, a capture engine that
 * takes cap_req_o pulses and a decoder that returns proc_done_i per frame.
 */
`timescale 1ns/1ps
`default_nettype none

module rcs_fifo #(
    parameter int W = 32,
    parameter int D = 8
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // fill side
    input wire logic in_valid_i,
    input wire logic [W-1:0] in_data_i,
    output logic in_ready_o,
    // drain side
    output logic out_valid_o,
    output logic [W-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(D);
    // pointers wrap naturally, so D must be a power of two
    logic [W-1:0] mem [D];
    logic [AW-1:0] wp, rp;
    logic [AW:0] cnt;
    wire push = in_valid_i & in_ready_o;
    wire pop = out_valid_o & out_ready_i;
    wire [AW:0] next_cnt = (AW+1)'(cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    assign out_valid_o = cnt != '0;
    assign out_data_o = mem[rp];
    for (genvar i = 0; i < D; i++) begin : g_ent
        always_ff @(posedge mclk_i) begin
            if (push && wp == AW'(i)) begin
                mem[i] <= in_data_i;
            end
        end
    end
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
            in_ready_o <= 1'b1;
        end else begin
            wp <= push ? AW'(wp + 1'b1) : wp;
            rp <= pop ? AW'(rp + 1'b1) : rp;
            cnt <= next_cnt;
            in_ready_o <= next_cnt != (AW+1)'(D);
        end
    end
endmodule

module rcs_seq #(
    parameter int NBUF = 8,
    parameter int FIFO_D = 8,
    parameter int CYC_PER_MS = rcs_pkg::CYC_PER_MS
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // triggers
    input wire logic trig_pin_i,
    input wire logic ser_valid_i,
    input wire logic [7:0] ser_data_i,
    // capture engine
    output logic cap_req_o,
    output logic [$clog2(NBUF)-1:0] cap_idx_o,
    output logic [18:0] exposure_o,
    output logic [6:0] gain_o,
    // decoder
    output logic proc_start_o,
    output logic [$clog2(NBUF)-1:0] proc_idx_o,
    input wire logic proc_done_i,
    input wire logic sym_found_i,
    // result stream in and out
    input wire logic res_valid_i,
    input wire logic [31:0] res_data_i,
    output logic res_ready_o,
    output logic out_valid_o,
    output logic [31:0] out_data_o,
    input wire logic out_ready_i,
    // status
    output logic cyc_active_o
);
    localparam int IW = $clog2(NBUF);
    localparam int PW = IW + 1;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    logic [31:0] ctrl, chars, caps, tout, filt, expo, gain;
    rcs_pkg::rcs_state_t state, next_state;

    // axi write path: address and data latched independently
    wire wr_do = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    logic [7:0] aw_q;
    logic [31:0] w_q;
    logic [3:0] ws_q;
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[8*b +: 8] = d[8*b +: 8];
            end
        end
        return r;
    endfunction
    function automatic logic hit(input logic [7:0] a, input logic [7:0] k);
        return {a[7:2], 2'b00} == k;
    endfunction
    wire w_map = aw_q[7:2] <= rcs_pkg::A_GAIN[7:2];
    wire r_map = s_axi_araddr[7:2] <= rcs_pkg::A_STAT[7:2];

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= rcs_pkg::RESP_OK;
            aw_q <= '0;
            w_q <= '0;
            ws_q <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                aw_q <= s_axi_awaddr;
            end else if (wr_do) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                w_q <= s_axi_wdata;
                ws_q <= s_axi_wstrb;
            end else if (wr_do) begin
                s_axi_wready <= 1'b1;
            end
            if (wr_do) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= w_map ? rcs_pkg::RESP_OK : rcs_pkg::RESP_ERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl <= rcs_pkg::CTRL_RST;
            chars <= rcs_pkg::CHARS_RST;
            caps <= rcs_pkg::CAPS_RST;
            tout <= rcs_pkg::TOUT_RST;
            filt <= rcs_pkg::FILT_RST;
            expo <= rcs_pkg::EXPO_RST;
            gain <= rcs_pkg::GAIN_RST;
        end else if (wr_do) begin
            if (hit(aw_q, rcs_pkg::A_CTRL)) ctrl <= merge(ctrl, w_q, ws_q);
            if (hit(aw_q, rcs_pkg::A_CHARS)) chars <= merge(chars, w_q, ws_q);
            if (hit(aw_q, rcs_pkg::A_CAPS)) caps <= merge(caps, w_q, ws_q);
            if (hit(aw_q, rcs_pkg::A_TOUT)) tout <= merge(tout, w_q, ws_q);
            if (hit(aw_q, rcs_pkg::A_FILT)) filt <= merge(filt, w_q, ws_q);
            if (hit(aw_q, rcs_pkg::A_EXPO)) expo <= merge(expo, w_q, ws_q);
            if (hit(aw_q, rcs_pkg::A_GAIN)) gain <= merge(gain, w_q, ws_q);
        end
    end

    // read path
    logic [PW-1:0] pending;
    logic busy, tmo_seen;
    logic [7:0] cap_cnt, found_cnt;
    wire [31:0] stat = {found_cnt, cap_cnt, 4'(pending), 2'b00, tmo_seen, busy, 5'h00, state};
    wire [31:0] rd_mux = hit(s_axi_araddr, rcs_pkg::A_CTRL) ? ctrl :
                         hit(s_axi_araddr, rcs_pkg::A_CHARS) ? chars :
                         hit(s_axi_araddr, rcs_pkg::A_CAPS) ? caps :
                         hit(s_axi_araddr, rcs_pkg::A_TOUT) ? tout :
                         hit(s_axi_araddr, rcs_pkg::A_FILT) ? filt :
                         hit(s_axi_araddr, rcs_pkg::A_EXPO) ? expo :
                         hit(s_axi_araddr, rcs_pkg::A_GAIN) ? gain :
                         hit(s_axi_araddr, rcs_pkg::A_STAT) ? stat : 32'h0000_0000;
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= rcs_pkg::RESP_OK;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= r_map ? rcs_pkg::RESP_OK : rcs_pkg::RESP_ERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // trigger pin: synchroniser then glitch filter
    logic trig_s1, trig_s2, flt;
    logic [22:0] fcnt;
    wire [22:0] flim = trig_s2 ? 23'(filt[15:0] * rcs_pkg::CYC_PER_US)
                               : 23'(filt[31:16] * rcs_pkg::CYC_PER_US);
    wire flt_set = (trig_s2 != flt) && (fcnt >= flim);
    wire rise = flt_set && trig_s2;
    wire fall = flt_set && !trig_s2;
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            trig_s1 <= 1'b0;
            trig_s2 <= 1'b0;
            flt <= 1'b0;
            fcnt <= '0;
        end else begin
            trig_s1 <= trig_pin_i;
            trig_s2 <= trig_s1;
            fcnt <= (trig_s2 == flt || flt_set) ? '0 : 23'(fcnt + 1'b1);
            flt <= flt_set ? trig_s2 : flt;
        end
    end

    // mode decode
    wire [1:0] mode = ctrl[rcs_pkg::F_MODE +: 2];
    wire ser_en = ctrl[rcs_pkg::F_SER];
    wire defer = ctrl[rcs_pkg::F_DEFER];
    wire [2:0] src = ctrl[rcs_pkg::F_SRC +: 3];
    wire [2:0] endc = ctrl[rcs_pkg::F_END +: 3];
    wire is_trig = mode == rcs_pkg::RCS_M_TRIG;
    wire is_ss = mode == rcs_pkg::RCS_M_SS;
    wire is_cust = mode == rcs_pkg::RCS_M_CUST;
    wire idle = state == rcs_pkg::ST_IDLE;
    wire run = state == rcs_pkg::ST_RUN;
    wire sc_trig = ser_valid_i && ser_data_i == chars[7:0];
    wire sc_start = ser_en && ser_valid_i && ser_data_i == chars[15:8];
    wire sc_stop = ser_en && ser_valid_i && ser_data_i == chars[23:16];
    wire trig_evt = sc_trig || rise;
    wire cust_trig = (src == rcs_pkg::SRC_LVL || src == rcs_pkg::SRC_EDGE) ? rise :
                     src == rcs_pkg::SRC_SER ? sc_trig :
                     src == rcs_pkg::SRC_SERE ? trig_evt : 1'b0;
    // level high or start char opens; level low or stop char closes
    wire ss_start = rise || sc_start;
    wire stop_evt = fall || sc_stop;
    wire start_evt = is_trig ? trig_evt : is_ss ? ss_start :
                     is_cust ? (cust_trig || src == rcs_pkg::SRC_CONT) : 1'b0;
    wire new_trig = is_trig ? trig_evt : is_cust ? cust_trig : 1'b0;

    // end-of-cycle terms
    logic [15:0] ms_cnt;
    logic [23:0] pre;
    wire tmo = !idle && ms_cnt >= tout[15:0];
    wire lim_hit = caps[7:0] != 8'h00 && cap_cnt >= caps[7:0];
    wire drained = pending == '0 && !busy && !cap_req_o;
    wire last_fr = lim_hit && drained;
    wire all_found = caps[15:8] != 8'h00 && found_cnt >= caps[15:8];
    wire ends_tmo = is_trig || endc == rcs_pkg::END_TO || endc == rcs_pkg::END_TO_NEW;
    wire ends_new = is_cust && (endc == rcs_pkg::END_NEW || endc == rcs_pkg::END_TO_NEW ||
                                endc == rcs_pkg::END_LF_NEW);
    wire ends_lf = is_trig || endc == rcs_pkg::END_LF || endc == rcs_pkg::END_LF_NEW;
    wire end_evt = all_found || (ends_tmo && tmo) || (ends_new && new_trig) ||
                   (ends_lf && last_fr) || (is_cust && src == rcs_pkg::SRC_LVL && fall);

    always_comb begin
        next_state = state;
        unique case (state)
            rcs_pkg::ST_IDLE: begin
                if (start_evt) next_state = rcs_pkg::ST_RUN;
            end
            rcs_pkg::ST_RUN: begin
                if (is_ss) begin
                    if (stop_evt) next_state = rcs_pkg::ST_IDLE;
                    else if (tmo) next_state = rcs_pkg::ST_HOLD;
                end else if (end_evt) begin
                    next_state = rcs_pkg::ST_IDLE;
                end
            end
            rcs_pkg::ST_HOLD: begin
                if (stop_evt) next_state = rcs_pkg::ST_IDLE;
            end
            default: next_state = rcs_pkg::ST_IDLE;
        endcase
    end

    // captures: continuous refills when the pool is empty, else one per trigger
    wire cont = is_ss || (is_cust && (src == rcs_pkg::SRC_CONT || src == rcs_pkg::SRC_LVL));
    wire room = pending < PW'(NBUF);
    wire cap_trig = run && !cont && new_trig && !ends_new && !lim_hit;
    wire cap_go = room && ((idle && start_evt) || cap_trig ||
                           (run && cont && pending == '0 && next_state == rcs_pkg::ST_RUN));
    // decode runs beside capture, frames taken in capture order
    wire proc_go = pending != '0 && !busy;
    wire [PW-1:0] next_pending = PW'(pending + {{IW{1'b0}}, cap_go} - {{IW{1'b0}}, proc_go});
    wire [31:0] ex_clip = expo < rcs_pkg::EXP_MIN_US ? rcs_pkg::EXP_MIN_US :
                          expo > rcs_pkg::EXP_MAX_US ? rcs_pkg::EXP_MAX_US : expo;
    wire [31:0] gn_clip = gain > rcs_pkg::GAIN_MAX_PCT ? rcs_pkg::GAIN_MAX_PCT : gain;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= rcs_pkg::ST_IDLE;
            cyc_active_o <= 1'b0;
            pending <= '0;
            busy <= 1'b0;
            cap_req_o <= 1'b0;
            cap_idx_o <= '0;
            proc_start_o <= 1'b0;
            proc_idx_o <= '0;
            exposure_o <= rcs_pkg::EXPO_RST[18:0];
            gain_o <= rcs_pkg::GAIN_RST[6:0];
        end else begin
            state <= next_state;
            cyc_active_o <= next_state != rcs_pkg::ST_IDLE;
            pending <= next_pending;
            busy <= proc_go || (busy && !proc_done_i);
            cap_req_o <= cap_go;
            cap_idx_o <= cap_req_o ? IW'(cap_idx_o + 1'b1) : cap_idx_o;
            proc_start_o <= proc_go;
            proc_idx_o <= proc_start_o ? IW'(proc_idx_o + 1'b1) : proc_idx_o;
            if (cap_go) begin
                exposure_o <= ex_clip[18:0];
                gain_o <= gn_clip[6:0];
            end
        end
    end

    // per-cycle counters, cleared while idle; the timeout flag clears on the next start
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cap_cnt <= '0;
            found_cnt <= '0;
            ms_cnt <= '0;
            pre <= '0;
            tmo_seen <= 1'b0;
        end else if (idle) begin
            cap_cnt <= '0;
            found_cnt <= '0;
            ms_cnt <= '0;
            pre <= '0;
            tmo_seen <= start_evt ? 1'b0 : tmo_seen;
        end else begin
            cap_cnt <= cap_trig && room ? 8'(cap_cnt + 1'b1) : cap_cnt;
            found_cnt <= sym_found_i && found_cnt != 8'hff ? 8'(found_cnt + 1'b1) : found_cnt;
            pre <= (pre == 24'(CYC_PER_MS - 1)) ? '0 : 24'(pre + 1'b1);
            ms_cnt <= (pre == 24'(CYC_PER_MS - 1) && !tmo) ? 16'(ms_cnt + 1'b1) : ms_cnt;
            tmo_seen <= tmo_seen || tmo;
        end
    end

    // results: fifo then an output register; deferral holds the register empty
    logic f_valid;
    logic [31:0] f_data;
    wire rel = !defer || idle;
    wire ld = f_valid && rel && (!out_valid_o || out_ready_i);
    rcs_fifo #(.W(32), .D(FIFO_D)) u_fifo (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .in_valid_i(res_valid_i),
        .in_data_i(res_data_i),
        .in_ready_o(res_ready_o),
        .out_valid_o(f_valid),
        .out_data_o(f_data),
        .out_ready_i(ld)
    );
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            out_valid_o <= 1'b0;
            out_data_o <= '0;
        end else begin
            out_valid_o <= ld || (out_valid_o && !out_ready_i);
            out_data_o <= ld ? f_data : out_data_o;
        end
    end

    a_defer_hold: assert property (defer && !idle && !out_valid_o |=> !out_valid_o)
        else $error("result left during deferred cycle");
    a_ss_timeout: assert property (is_ss && run && tmo && !stop_evt |=>
            state == rcs_pkg::ST_HOLD)
        else $error("start/stop timeout did not hold cycle");
    a_hold_quiet: assert property (state == rcs_pkg::ST_HOLD |-> !cap_go)
        else $error("capture while held after timeout");
    a_ss_stop: assert property (is_ss && !idle && stop_evt |=> idle)
        else $error("stop trigger did not end cycle");
    a_cap_limit: assert property (is_trig && lim_hit && run |-> !cap_trig)
        else $error("capture beyond programmed count");
    a_trig_open: assert property (is_trig && idle && trig_evt && room |=> cap_req_o && run)
        else $error("trigger did not open cycle with capture");
    a_filt_edge: assert property ($rose(flt) |-> $past(trig_s2, 1) &&
            $past(fcnt, 1) >= $past(flim, 1))
        else $error("edge accepted before filter time");
    a_proc_order: assert property (proc_start_o |-> $past(pending, 1) != '0 && busy)
        else $error("processing started without stored frame");
    a_trig_tmo: assert property (is_trig && run && tmo |=> idle)
        else $error("timeout did not end triggered cycle");
    a_expo_range: assert property (exposure_o >= 19'h00010 && exposure_o <= 19'h61a80)
        else $error("exposure out of range");
    a_gain_range: assert property (gain_o <= 7'h64)
        else $error("gain out of range");
endmodule
`default_nettype wire

//--- rcs_pkg.sv
/*
 * Shared constants for the read-cycle trigger sequencer: register map,
 * field positions, reset values, mode and state codes, timing figures.
 * Assumes a 125 MHz device clock.
 */
`default_nettype none
package rcs_pkg;
    // register byte offsets
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_CHARS = 8'h04;
    localparam logic [7:0] A_CAPS = 8'h08;
    localparam logic [7:0] A_TOUT = 8'h0c;
    localparam logic [7:0] A_FILT = 8'h10;
    localparam logic [7:0] A_EXPO = 8'h14;
    localparam logic [7:0] A_GAIN = 8'h18;
    localparam logic [7:0] A_STAT = 8'h1c;
    // control field positions
    localparam int F_MODE = 0;
    localparam int F_SER = 2;
    localparam int F_DEFER = 3;
    localparam int F_SRC = 4;
    localparam int F_END = 8;
    // reset values: trigger char space, start S, stop E
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] CHARS_RST = 32'h0045_5320;
    localparam logic [31:0] CAPS_RST = 32'h0000_0101;
    localparam logic [31:0] TOUT_RST = 32'h0000_03e8;
    localparam logic [31:0] FILT_RST = 32'h0020_0020;
    localparam logic [31:0] EXPO_RST = 32'h0000_0b18;
    localparam logic [31:0] GAIN_RST = 32'h0000_0019;
    // axi responses
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
    // cycle modes
    typedef enum logic [1:0] {
        RCS_M_TRIG = 2'h0,
        RCS_M_SS = 2'h1,
        RCS_M_CUST = 2'h2
    } rcs_mode_t;
    // custom trigger sources
    localparam logic [2:0] SRC_CONT = 3'h0;
    localparam logic [2:0] SRC_LVL = 3'h1;
    localparam logic [2:0] SRC_EDGE = 3'h2;
    localparam logic [2:0] SRC_SER = 3'h3;
    localparam logic [2:0] SRC_SERE = 3'h4;
    // custom end-of-cycle conditions
    localparam logic [2:0] END_TO = 3'h0;
    localparam logic [2:0] END_NEW = 3'h1;
    localparam logic [2:0] END_TO_NEW = 3'h2;
    localparam logic [2:0] END_LF = 3'h3;
    localparam logic [2:0] END_LF_NEW = 3'h4;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN = 3'b010,
        ST_HOLD = 3'b100
    } rcs_state_t;
    // timing
    localparam int CLK_MHZ = 125;
    localparam int CYC_PER_US = CLK_MHZ;
    localparam int CYC_PER_MS = CLK_MHZ * 1000;
    localparam int FILT_US = 32;
    localparam int TOUT_MS = 1000;
    localparam logic [31:0] EXP_MIN_US = 32'h0000_0010;
    localparam logic [31:0] EXP_MAX_US = 32'h0006_1a80;
    localparam logic [31:0] GAIN_MAX_PCT = 32'h0000_0064;
endpackage
`default_nettype wire

//--- rcs_host.sv
/*
 * Host-side partner: serial trigger bytes and a frame decoder.
 * Assumes the sequencer's clock; the decoder delay dly keeps its default of 20, the bench never sets it.
 */
`timescale 1ns/1ps
`default_nettype none
module rcs_host (
    // clock
    input wire logic mclk_i,
    // decoder handshake
    input wire logic proc_start_i,
    output logic proc_done_o,
    // serial receiver strobe
    output logic ser_valid_o,
    output logic [7:0] ser_data_o
);
    int dly = 20;
    int cnt = 0;
    initial begin
        proc_done_o = 1'b0;
        ser_valid_o = 1'b0;
        ser_data_o = 8'h00;
    end
    // idle byte lane shows the inverse, never a stale copy
    task automatic send(input logic [7:0] c, input int gap);
        ser_valid_o <= 1'b1;
        ser_data_o <= c;
        @(posedge mclk_i);
        ser_valid_o <= 1'b0;
        ser_data_o <= ~c;
        repeat (gap) @(posedge mclk_i);
    endtask
    // one frame at a time, done pulse dly+1 cycles after the edge that samples start
    always @(posedge mclk_i) begin
        proc_done_o <= (cnt == 1);
        cnt <= proc_start_i ? dly + 1 : (cnt > 0 ? cnt - 1 : 0);
    end
endmodule
`default_nettype wire

//--- read_cycle_trigger_sequencer_tb_top.sv
/*
 * Self-checking bench for rcs_seq: registers over axi4-lite, trigger modes,
 * result stream through the fifo. Assumes rcs_host as trigger and decoder.
 */
`timescale 1ns/1ps
`default_nettype none
module read_cycle_trigger_sequencer_tb_top;
    logic mclk_i = 1'b0, rst_i = 1'b1, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic trig = 1'b0, res_valid = 1'b0, out_ready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, res_data = 32'h0, d, q[$];
    wire logic awready, wready, bvalid, arready, rvalid, cap_req, proc_start, proc_done;
    wire logic ser_valid, res_ready, out_valid, active;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata, out_data;
    wire logic [7:0] ser_data;
    wire logic [18:0] expo;
    wire logic [6:0] gain;
    wire logic [2:0] cidx, pidx;
    int failures = 0, compares = 0, ncap = 0, nproc = 0, n = 0, seed = 32'h84e64f87;
    logic [18:0] exp_expo = 19'd2840;
    logic [6:0] exp_gain = 7'd25;
    logic [31:0] rv[8] = '{rcs_pkg::CTRL_RST, rcs_pkg::CHARS_RST, rcs_pkg::CAPS_RST,
        rcs_pkg::TOUT_RST, rcs_pkg::FILT_RST, rcs_pkg::EXPO_RST, rcs_pkg::GAIN_RST, 32'h1};
    always #4 mclk_i = ~mclk_i;
    rcs_seq #(.CYC_PER_MS(10)) rcs_seq_inst (.mclk_i(mclk_i), .rst_i(rst_i),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
        .trig_pin_i(trig), .ser_valid_i(ser_valid), .ser_data_i(ser_data),
        .cap_req_o(cap_req), .cap_idx_o(cidx), .exposure_o(expo), .gain_o(gain),
        .proc_start_o(proc_start), .proc_idx_o(pidx), .proc_done_i(proc_done), .sym_found_i(1'b0),
        .res_valid_i(res_valid), .res_data_i(res_data), .res_ready_o(res_ready),
        .out_valid_o(out_valid), .out_data_o(out_data), .out_ready_i(out_ready),
        .cyc_active_o(active));
    rcs_host rcs_host_inst (.mclk_i(mclk_i), .proc_start_i(proc_start),
        .proc_done_o(proc_done), .ser_valid_o(ser_valid), .ser_data_o(ser_data));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            failures++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic summarize;
        if (failures == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge mclk_i);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        chk(32'(bresp), 32'(r));
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge mclk_i);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        v = rdata;
        chk(32'(rresp), 32'(r));
    endtask
    // result model: fifo order, one word per handshake
    always @(posedge mclk_i) begin
        if (cap_req) chk(32'(cidx), 32'(ncap % 8));
        if (proc_start) chk(32'(pidx), 32'(nproc % 8));
        if (proc_start) nproc++;
        if (cap_req) ncap++;
        if (cap_req) chk(32'(expo), 32'(exp_expo));
        if (cap_req) chk(32'(gain), 32'(exp_gain));
        if (res_valid && res_ready) q.push_back(res_data);
        if (out_valid && out_ready) chk(out_data, q.pop_front());
    end
    initial begin
        repeat (40000) @(posedge mclk_i);
        failures++;
        summarize();
    end
    initial begin
        repeat (4) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        for (int i = 0; i < 8; i++) begin
            rd(8'(4 * i), d, rcs_pkg::RESP_OK);
            chk(d, rv[i]);
        end
        rd(8'h20, d, rcs_pkg::RESP_ERR);
        wr(rcs_pkg::A_STAT, 32'h0, rcs_pkg::RESP_ERR);
        wr(rcs_pkg::A_FILT, 32'h0, rcs_pkg::RESP_OK);
        wr(rcs_pkg::A_EXPO, 32'h5, rcs_pkg::RESP_OK);
        wr(rcs_pkg::A_GAIN, 32'hc8, rcs_pkg::RESP_OK);
        exp_expo = 19'd16;
        exp_gain = 7'd100;
        // four quick triggers while frame one decodes: only one extra capture
        for (int i = 0; i < 4; i++) rcs_host_inst.send(8'h20, 2);
        while (active) @(posedge mclk_i);
        chk(32'(ncap), 32'h2);
        wr(rcs_pkg::A_CTRL, 32'h5, rcs_pkg::RESP_OK);
        wr(rcs_pkg::A_TOUT, 32'h1, rcs_pkg::RESP_OK);
        rcs_host_inst.send(8'h53, 40);
        chk(32'(active), 32'h1);
        rd(rcs_pkg::A_STAT, d, rcs_pkg::RESP_OK);
        chk(32'(d[2:0]), 32'h4);
        rcs_host_inst.send(8'h45, 3);
        chk(32'(active), 32'h0);
        wr(rcs_pkg::A_CTRL, 32'h1, rcs_pkg::RESP_OK);
        wr(rcs_pkg::A_TOUT, 32'h3e8, rcs_pkg::RESP_OK);
        trig <= 1'b1;
        repeat (8) @(posedge mclk_i);
        chk(32'(active), 32'h1);
        trig <= 1'b0;
        repeat (8) @(posedge mclk_i);
        chk(32'(active), 32'h0);
        // custom, serial source, ends on new trigger; results held while open
        wr(rcs_pkg::A_CTRL, 32'h13a, rcs_pkg::RESP_OK);
        rcs_host_inst.send(8'h20, 3);
        chk(32'(active), 32'h1);
        res_valid <= 1'b1;
        res_data <= $random(seed);
        @(posedge mclk_i);
        res_valid <= 1'b0;
        repeat (4) @(posedge mclk_i);
        chk(32'(out_valid), 32'h0);
        rcs_host_inst.send(8'h20, 3);
        chk(32'(active), 32'h0);
        // fill with output stalled until refused, then drain at random pace
        res_valid <= 1'b1;
        res_data <= $random(seed);
        do begin
            @(posedge mclk_i);
            n++;
            if (res_ready) res_data <= $random(seed);
        end while (res_ready);
        chk(32'(n > 8), 32'h1);
        while (q.size() > 0 || res_valid) begin
            @(posedge mclk_i);
            if (res_ready) res_valid <= 1'b0;
            out_ready <= 1'($random(seed));
        end
        summarize();
    end
endmodule
`default_nettype wire
